// File: rtl/sps_pkg.sv
// SPI port package: register map, reset values, pin and state layouts.
// Assumes an 8-bit register bus on one system clock and pins outside that clock domain.
// Function
// - Busy bit reads 1 while a transfer runs, master or slave.
// - Master enable 1 selects master operation, 0 selects slave.
// - Phase 0 centres data on first clock edge, 1 on second.
// - Polarity selects idle clock level, low for 0, high for 1.
// - Selected flag follows the de-glitched select pin, 1 when low.
// - Raw select bit returns the unfiltered pin level at read time.
// - Slave shifter empty sets after a byte, clears on load or edge.
// - In master operation shifter empty and receive empty read 1.
// - Slave receive empty reads 0 while an unread byte is held.
// - Slave samples mid bit; master samples one clock before bit end.
// - Done flag sets after every byte; only software clears it.
// - Data write while the transmit buffer is full sets a sticky collision flag.
// - Master with select mode 01 and select low sets mode fault.
// - Slave byte end with unread receive byte sets sticky overrun.
// - Select mode 00 unused pin, 01 input, 1x drive low mode bit.
// - Transmit empty clears on data write, sets when shifter loads.
// - Port enable 0 disables the port, 1 enables it.
// - Master clock is system clock over two times divider plus one.
// - Data write fills transmit buffer and starts master; read gives rx.
// - Mode fault clears master enable and port enable.
// - A colliding write is dropped; transmit buffer stays unchanged.
// - On overrun the old byte is kept and the new one lost.
// - Four-wire slave works only while selected; deselect resets count.
package sps_pkg;
  localparam logic [7:0] A_CFG = 8'h9A;
  localparam logic [7:0] A_DAT = 8'h9B;
  localparam logic [7:0] A_DIV = 8'h9D;
  localparam logic [7:0] A_CTL = 8'hF8;
  localparam logic [7:0] CFG_RST = 8'h07;
  localparam logic [7:0] CTL_RST = 8'h06;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [1:0] MD_3W = 2'h0;
  localparam logic [1:0] MD_4W = 2'h1;
  localparam logic [3:0] LAST_HALF = 4'hF;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [3:0] PIN_RST = 4'h1;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic nss_n;
  } sps_pin_t;
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic nss_n;
    logic nss_oe;
  } sps_pout_t;
  typedef struct packed {
    logic master;
    logic cpha;
    logic cpol;
    logic done;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic ovr;
    logic [1:0] mode;
    logic en;
    logic [7:0] div;
    logic [7:0] txb;
    logic tx_full;
    logic [7:0] rxb;
    logic rx_full;
    logic [7:0] tsh;
    logic [7:0] rsh;
    logic shifter_empty;
    logic run;
    logic [3:0] h;
    logic [7:0] cnt;
    logic [3:0] ecnt;
    sps_pin_t pf;
    logic [7:0] rdata;
    sps_pout_t po;
    logic irq;
  } sps_st_t;
  localparam sps_st_t ST_RST = '{mode: CTL_RST[3:2], shifter_empty: CFG_RST[1],
    div: DIV_RST, txb: DAT_RST, rxb: DAT_RST, pf: PIN_RST, default: '0};
endpackage

// File: rtl/sps_port.sv
// SPI master/slave port with its four byte registers.
// Assumes pins are outside the clock domain and the bus is synchronous.
`timescale 1ns/10ps
module sps_port (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire sps_pkg::sps_pin_t pin_in,
  output sps_pkg::sps_pout_t pin_out,
  output logic port_irq
);
  sps_pkg::sps_st_t st_q;
  sps_pkg::sps_st_t n;
  sps_pkg::sps_pin_t s0;
  sps_pkg::sps_pin_t s1;
  sps_pkg::sps_pin_t s2;
  sps_pkg::sps_pin_t f;
  logic sel;
  logic act;
  logic sedge;
  logic lead;
  logic samp;
  logic tick;
  logic busy;
  logic fin;

  assign sfr_rdata = st_q.rdata;
  assign pin_out = st_q.po;
  assign port_irq = st_q.irq;
  assign busy = st_q.run | (st_q.ecnt != 4'h0);

  // Pins cross in through three flops; the filter reads only the last two
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s0 <= sps_pkg::PIN_RST;
      s1 <= sps_pkg::PIN_RST;
      s2 <= sps_pkg::PIN_RST;
    end
    else
    begin
      s0 <= pin_in;
      s1 <= s0;
      s2 <= s1;
    end
  end

  always_comb
  begin
    n = st_q;
    f = st_q.pf;
    for (int i = 0; i < 4; i++)
    begin
      if (s1[i] == s2[i])
        f[i] = s2[i];
    end
    n.pf = f;
    sel = !f.nss_n;
    // Mode 1x as slave has no select input, so it acts like three-wire
    act = st_q.en & !st_q.master
      & ((st_q.mode != sps_pkg::MD_4W) | sel);
    sedge = (f.sck != st_q.pf.sck) & act;
    lead = f.sck != st_q.cpol;
    samp = lead ^ st_q.cpha;
    tick = st_q.cnt == st_q.div;
    fin = 1'b0;
    if (sfr_wr)
    begin
      case (sfr_addr)
        sps_pkg::A_CFG:
        begin
          n.master = sfr_wdata[6];
          n.cpha = sfr_wdata[5];
          n.cpol = sfr_wdata[4];
        end
        sps_pkg::A_CTL:
        begin
          n.done = sfr_wdata[7];
          n.write_collision_flag = sfr_wdata[6];
          n.mode_fault_flag = sfr_wdata[5];
          n.ovr = sfr_wdata[4];
          n.mode = sfr_wdata[3:2];
          n.en = sfr_wdata[0];
        end
        sps_pkg::A_DIV:
          n.div = sfr_wdata;
        sps_pkg::A_DAT:
        begin
          // A full buffer means a byte is still pending: drop the write
          if (st_q.tx_full)
            n.write_collision_flag = 1'b1;
          else
          begin
            n.txb = sfr_wdata;
            n.tx_full = 1'b1;
          end
        end
        default:
          n.write_collision_flag = st_q.write_collision_flag;
      endcase
    end
    if (sfr_rd)
    begin
      case (sfr_addr)
        sps_pkg::A_CFG:
          n.rdata = {busy, st_q.master, st_q.cpha, st_q.cpol,
            !st_q.pf.nss_n, s1.nss_n, st_q.master | st_q.shifter_empty,
            st_q.master | !st_q.rx_full};
        sps_pkg::A_CTL:
          n.rdata = {st_q.done, st_q.write_collision_flag, st_q.mode_fault_flag, st_q.ovr,
            st_q.mode, !st_q.tx_full, st_q.en};
        sps_pkg::A_DIV:
          n.rdata = st_q.div;
        sps_pkg::A_DAT:
        begin
          n.rdata = st_q.rxb;
          n.rx_full = 1'b0;
        end
        default:
          n.rdata = 8'h00;
      endcase
    end
    // Master engine: sixteen half periods of div+1 cycles each
    if (!st_q.en || !st_q.master)
    begin
      n.run = 1'b0;
      n.h = 4'h0;
      n.cnt = 8'h00;
    end
    else if (!st_q.run)
    begin
      n.h = 4'h0;
      n.cnt = 8'h00;
      if (st_q.tx_full)
      begin
        n.tsh = st_q.txb;
        n.tx_full = 1'b0;
        n.run = 1'b1;
      end
    end
    else
    begin
      n.cnt = st_q.cnt + 8'h01;
      if (tick)
      begin
        n.cnt = 8'h00;
        n.h = st_q.h + 4'h1;
        if (st_q.h[0])
        begin
          // Last cycle of the bit gives the slave the most settling time
          n.rsh = {st_q.rsh[6:0], f.miso};
          if (st_q.h != sps_pkg::LAST_HALF)
            n.tsh = {st_q.tsh[6:0], 1'b0};
        end
        if (st_q.h == sps_pkg::LAST_HALF)
        begin
          n.run = 1'b0;
          n.h = 4'h0;
          fin = 1'b1;
          n.rxb = n.rsh;
          n.rx_full = 1'b1;
        end
      end
    end
    // Slave engine: counts sixteen clock edges per byte
    if (!act)
      n.ecnt = 4'h0;
    else if (sedge)
    begin
      n.shifter_empty = 1'b0;
      n.ecnt = st_q.ecnt + 4'h1;
      if (samp)
        n.rsh = {st_q.rsh[6:0], f.mosi};
      else if (st_q.cpha ? st_q.ecnt != 4'h0
               : st_q.ecnt != sps_pkg::LAST_EDGE)
        n.tsh = {st_q.tsh[6:0], 1'b0};
      if (st_q.ecnt == sps_pkg::LAST_EDGE)
      begin
        fin = 1'b1;
        if (n.rx_full)
          n.ovr = 1'b1;
        else
        begin
          n.rxb = n.rsh;
          n.rx_full = 1'b1;
        end
        n.shifter_empty = !st_q.tx_full;
        if (st_q.tx_full)
        begin
          n.tsh = st_q.txb;
          n.tx_full = 1'b0;
        end
      end
    end
    // An empty slave shifter takes the buffer at once, selected or not
    if (st_q.en && !st_q.master && !sedge && st_q.shifter_empty && st_q.tx_full
      && st_q.ecnt == 4'h0)
    begin
      n.tsh = st_q.txb;
      n.tx_full = 1'b0;
      n.shifter_empty = 1'b0;
    end
    if (fin)
      n.done = 1'b1;
    if (st_q.en && st_q.master && st_q.mode == sps_pkg::MD_4W && sel)
    begin
      n.mode_fault_flag = 1'b1;
      n.master = 1'b0;
      n.en = 1'b0;
      n.run = 1'b0;
      n.h = 4'h0;
    end
    n.po.sck = n.run ? n.cpol ^ (n.cpha ? !n.h[0] : n.h[0])
      : n.cpol;
    n.po.sck_oe = n.en & n.master;
    n.po.mosi = n.tsh[7];
    n.po.mosi_oe = n.en & n.master;
    n.po.miso = n.tsh[7];
    n.po.miso_oe = n.en & !n.master
      & ((n.mode != sps_pkg::MD_4W) | !f.nss_n);
    n.po.nss_n = n.mode[0];
    n.po.nss_oe = n.mode[1];
    n.irq = n.done | n.write_collision_flag | n.mode_fault_flag | n.ovr;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_q <= sps_pkg::ST_RST;
    else
      st_q <= n;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_tick;
    st_q.run && tick && st_q.h != sps_pkg::LAST_HALF
      |=> pin_out.sck != $past(pin_out.sck);
  endproperty
  a_tick: assert property (p_tick)
    else $error("master clock missed a toggle");

  property p_hold;
    st_q.run && !tick |=> $stable(pin_out.sck);
  endproperty
  a_hold: assert property (p_hold)
    else $error("master clock toggled early");

  property p_idle;
    !st_q.run |-> pin_out.sck == st_q.cpol && st_q.h == 4'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle clock level wrong");

  property p_write_collision_flag;
    sfr_wr && sfr_addr == sps_pkg::A_DAT && st_q.tx_full
      |=> st_q.write_collision_flag && $stable(st_q.txb);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("collision not flagged or buffer changed");

  property p_txw;
    sfr_wr && sfr_addr == sps_pkg::A_DAT && !st_q.tx_full
      |=> st_q.txb == $past(sfr_wdata) || st_q.tsh == $past(sfr_wdata);
  endproperty
  a_txw: assert property (p_txw)
    else $error("data write lost");

  property p_mode_fault_flag;
    st_q.en && st_q.master && st_q.mode == sps_pkg::MD_4W && sel
      |=> st_q.mode_fault_flag && !st_q.en && !st_q.master ##1 port_irq;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag)
    else $error("mode fault not handled");

  property p_done;
    st_q.done && !(sfr_wr && sfr_addr == sps_pkg::A_CTL)
      |=> st_q.done;
  endproperty
  a_done: assert property (p_done)
    else $error("done flag cleared by hardware");

  property p_ovr;
    $rose(st_q.ovr) && !$past(sfr_wr) |-> $stable(st_q.rxb);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun replaced held byte");

  property p_mrd;
    sfr_rd && sfr_addr == sps_pkg::A_CFG && st_q.master
      |=> sfr_rdata[1:0] == 2'h3;
  endproperty
  a_mrd: assert property (p_mrd)
    else $error("master status bits not forced");

  property p_off;
    !st_q.en |-> !pin_out.sck_oe && !pin_out.miso_oe;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled port drives pins");

  c_mfin: cover property (st_q.run ##1 !st_q.run && st_q.done);
  c_sfin: cover property (!st_q.master && $rose(st_q.rx_full));
  c_ovr: cover property ($rose(st_q.ovr));
  c_mode_fault_flag: cover property ($rose(st_q.mode_fault_flag));
endmodule

// File: tb/sps_far.sv
// Far-side model: SPI slave while the port masters, master on demand.
// Assumes phase 0, polarity 0 and a system clock shared with the bench.
`timescale 1ns/10ps
module sps_far (
  input wire logic clock,
  input wire sps_pkg::sps_pout_t po,
  output sps_pkg::sps_pin_t pi
);
  logic [7:0] sh;
  logic [7:0] rx;
  logic mst;
  initial
  begin
    pi = 4'h1;
    sh = 8'h00;
    rx = 8'h00;
    mst = 1'b0;
  end
  always @(posedge po.sck)
    if (!mst)
      rx <= {rx[6:0], po.mosi};
  always @(negedge po.sck)
    if (!mst)
      sh <= {sh[6:0], 1'b0};
  // Idle lines toggle so a stale level never passes for data
  always @(posedge clock)
    if (mst)
      pi.miso <= ~pi.miso;
    else
    begin
      pi.miso <= sh[7];
      pi.mosi <= ~pi.mosi;
    end
  task automatic load(input logic [7:0] b);
    sh = b;
  endtask
  task automatic sel(input logic s);
    @(posedge clock);
    pi.nss_n <= ~s;
  endtask
  // Half period of 8 cycles leaves room for the port's pin filter
  task automatic mxfer(input logic [7:0] b);
    int i;
    mst = 1'b1;
    sel(1'b1);
    repeat (8) @(posedge clock);
    for (i = 7; i >= 0; i--)
    begin
      pi.mosi <= b[i];
      repeat (8) @(posedge clock);
      pi.sck <= 1'b1;
      rx <= {rx[6:0], po.miso};
      repeat (8) @(posedge clock);
      pi.sck <= 1'b0;
    end
    repeat (8) @(posedge clock);
    sel(1'b0);
    repeat (8) @(posedge clock);
    mst = 1'b0;
  endtask
endmodule

// File: tb/sps_port_tb.sv
// Self-checking bench for the SPI port: register tasks and link tests.
// Assumes the far-side model sps_far on the pins and a 100 MHz clock.
`timescale 1ns/10ps
module sps_port_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  sps_pkg::sps_pin_t pin_in;
  sps_pkg::sps_pout_t pin_out;
  logic port_irq;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] v;
  logic [7:0] e;
  int n;
  always #5 clock = ~clock;
  sps_port sps_port_i (.clock(clock), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .port_irq(port_irq));
  sps_far sps_far_i (.clock(clock), .po(pin_out), .pi(pin_in));
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] g,
    input logic [7:0] x);
    samples_checked++;
    if (g !== x)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(posedge clock);
    v = sfr_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x,
    input string s, input logic [7:0] m = 8'hFF);
    rd(a);
    chk(s, v & m, x);
  endtask
  // Polling keeps the bench independent of the exact byte length
  task automatic wdone();
    int i;
    v = 8'h00;
    for (i = 0; i < 300 && !v[7]; i++)
      rd(8'hF8);
    chk("done wait", v & 8'h80, 8'h80);
    if (!v[7])
      summarize();
  endtask
  task automatic per(output int p);
    int i;
    int t0;
    logic q;
    t0 = -1;
    p = 0;
    q = pin_out.sck;
    for (i = 0; i < 400 && p == 0; i++)
    begin
      @(posedge clock);
      if (pin_out.sck && !q)
        if (t0 < 0)
          t0 = i;
        else
          p = i - t0;
      q = pin_out.sck;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rc(8'h9A, 8'h07, "cfg rst");
    rc(8'hF8, 8'h06, "ctl rst");
    rc(8'h9D, 8'h00, "div rst");
    rc(8'h9B, 8'h00, "dat rst");
    rc(8'h00, 8'h00, "unmapped");
    wr(8'h9A, 8'h8F);
    rc(8'h9A, 8'h07, "cfg ro");
    $display("test reset done");
    wr(8'h9D, 8'h07);
    rc(8'h9D, 8'h07, "div");
    wr(8'hF8, 8'h01);
    wr(8'h9A, 8'h40);
    rc(8'h9A, 8'h47, "cfg mst");
    sps_far_i.load(8'h3C);
    wr(8'h9B, 8'hA5);
    per(n);
    chk("sck period", n[7:0], 8'h10);
    rc(8'h9A, 8'hC7, "busy");
    wdone();
    chk("irq", {7'h00, port_irq}, 8'h01);
    rc(8'h9B, 8'h3C, "mst rx");
    chk("far rx", sps_far_i.rx, 8'hA5);
    chk("sck idle", {7'h00, pin_out.sck}, 8'h00);
    wr(8'hF8, 8'h01);
    rc(8'hF8, 8'h03, "clr");
    wr(8'h9A, 8'h50);
    rc(8'h9A, 8'h57, "cpol");
    chk("sck hi", {7'h00, pin_out.sck}, 8'h01);
    wr(8'h9A, 8'h40);
    $display("test master done");
    wr(8'h9B, 8'h11);
    wr(8'h9B, 8'h22);
    wr(8'h9B, 8'h33);
    rc(8'hF8, 8'h41, "write_collision_flag");
    wdone();
    wr(8'hF8, 8'h01);
    wdone();
    repeat (200) @(posedge clock);
    chk("far rx2", sps_far_i.rx, 8'h22);
    rc(8'hF8, 8'h83, "ctl idle");
    rc(8'h9B, 8'h00, "rx2");
    wr(8'hF8, 8'h01);
    wr(8'h9A, 8'h60);
    wr(8'h9B, 8'h0F);
    repeat (4) @(posedge clock);
    chk("cpha sck", {7'h00, pin_out.sck}, 8'h01);
    wdone();
    chk("cpha idle", {7'h00, pin_out.sck}, 8'h00);
    rc(8'h9B, 8'h00, "cpha rx");
    wr(8'h9A, 8'h40);
    $display("test collision done");
    wr(8'hF8, 8'h05);
    sps_far_i.sel(1'b1);
    repeat (10) @(posedge clock);
    rc(8'hF8, 8'h26, "mode_fault_flag");
    rc(8'h9A, 8'h08, "cfg mode_fault_flag", 8'hCC);
    chk("irq", {7'h00, port_irq}, 8'h01);
    sps_far_i.sel(1'b0);
    for (n = 0; n < 4; n++)
    begin
      wr(8'hF8, {4'h0, n[1:0], 2'h0});
      repeat (2) @(posedge clock);
      e = {6'h00, n[1], n[0] | ~n[1]};
      chk("nss", {6'h00, pin_out.nss_oe, pin_out.nss_n | ~n[1]}, e);
    end
    $display("test fault done");
    wr(8'hF8, 8'h05);
    wr(8'h9B, 8'hC3);
    rc(8'h9A, 8'h05, "shifter_empty");
    sps_far_i.mxfer(8'h5A);
    chk("far rx3", sps_far_i.rx, 8'hC3);
    rc(8'hF8, 8'h87, "slv done");
    rc(8'h9A, 8'h06, "rx full");
    sps_far_i.mxfer(8'h77);
    rc(8'hF8, 8'h97, "ovr");
    rc(8'h9B, 8'h5A, "keep");
    rc(8'h9A, 8'h07, "rx empty");
    $display("test slave done");
    summarize();
  end
endmodule
